// [src/imc_ctrl.sv]
// i2c master sequence control: control register, bus-condition engine
// assumes CLK (register side) and LINK_CLK (bit engine) are unrelated;
// sda and scl are open drain, pulled up outside the block.
//
// Notes on behaviour
// - in slave role, stretch enable with release clear holds scl low
// - ack sequence drives the stored ack value: one is nack, zero ack
// - ack go bit drives an ack slot, hardware clears it when done
// - receive go bit takes one byte, cleared after the eighth bit
// - stop go bit makes a stop condition, cleared when it ends
// - repeated start go bit makes a repeated start, cleared at end
// - start go bit makes a start condition, cleared at its end
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module imc_ctrl
   import imc_pkg::*;
#(
   parameter int QTR_CYC = IMC_QTR_CYC
) (
   // register side clock and reset
   input  wire logic          CLK,
   input  wire logic          RST_B,
   // avalon-mm slave
   input  wire logic [AW-1:0] ADDRESS,
   input  wire logic          READ,
   input  wire logic          WRITE,
   input  wire logic [31:0]   WRITEDATA,
   input  wire logic [3:0]    BYTEENABLE,
   output logic      [31:0]   READDATA,
   output logic               WAITREQUEST,
   // link clock
   input  wire logic          LINK_CLK,
   // serial data pin
   input  wire logic          SDA_IN,
   output logic               SDA_OUT,
   output logic               SDA_OE,
   // serial clock pin
   input  wire logic          SCL_IN,
   output logic               SCL_OUT,
   output logic               SCL_OE
);
   import imc_pkg::*;

   if (QTR_CYC < 1 || QTR_CYC > 255) begin : g_chk
      $error("QTR_CYC out of range");
   end

   localparam logic [7:0] QLAST = 8'(QTR_CYC - 1);

   // ****************************************
   // register side
   // ****************************************
   logic [15:0]  ctrl;
   logic [15:0]  next_ctrl;
   logic [7:0]   rx_data;
   logic [7:0]   next_rx_data;
   logic [31:0]  next_readdata;
   logic         next_waitreq;
   logic         req_tgl;
   logic         next_req_tgl;
   imc_state_t   cmd;
   imc_state_t   next_cmd;
   logic         done_s1;
   logic         done_s2;
   logic         done_s3;
   logic         wr_ok;
   logic         busy;
   logic [15:0]  wval;
   logic [7:0]   lk_rx;
   logic         lk_done;

   // go bits of a sequence still running
   assign busy  = |ctrl[IMC_B_ACKGO:IMC_B_START];
   assign wr_ok = WRITE && !WAITREQUEST && ADDRESS == IMC_OFS_CONTROL;

   always_comb begin
      wval          = ctrl;
      next_ctrl     = ctrl;
      next_rx_data  = rx_data;
      next_req_tgl  = req_tgl;
      next_cmd      = cmd;
      next_waitreq  = 1'b1;
      next_readdata = READDATA;
      // one wait state, then the request is taken on the low edge
      if ((READ || WRITE) && WAITREQUEST) begin
         next_waitreq = 1'b0;
         // writes leave read data alone so it stands until the next read
         if (READ) begin
            case (ADDRESS)
               IMC_OFS_CONTROL: next_readdata = {16'h0000, ctrl};
               IMC_OFS_RXDATA:  next_readdata = {24'h000000, rx_data};
               default:         next_readdata = 32'h00000000;
            endcase
         end
      end
      // completion from the link side clears the go bits
      if (done_s2 != done_s3) begin
         next_ctrl[IMC_B_ACKGO:IMC_B_START] = 5'h00;
         next_rx_data = lk_rx;
      end
      if (wr_ok) begin
         if (BYTEENABLE[0]) begin
            wval[7:0] = WRITEDATA[7:0];
         end
         if (BYTEENABLE[1]) begin
            wval[15:8] = WRITEDATA[15:8];
         end
         wval = wval & IMC_CTRL_MASK;
         // go bits of a running sequence are kept, new ones ignored
         next_ctrl[15:5] = wval[15:5];
         if (!busy && !wval[IMC_B_MGMT]) begin
            next_cmd = IMC_IDLE;
            if (wval[IMC_B_START]) begin
               next_cmd = IMC_START;
            end else if (wval[IMC_B_RSTART]) begin
               next_cmd = IMC_RSTART;
            end else if (wval[IMC_B_STOP]) begin
               next_cmd = IMC_STOP;
            end else if (wval[IMC_B_RECV]) begin
               next_cmd = IMC_RECV;
            end else if (wval[IMC_B_ACKGO]) begin
               next_cmd = IMC_ACK;
            end
            // only the winning go bit is kept
            next_ctrl[IMC_B_ACKGO:IMC_B_START] = next_cmd[5:1];
            if (next_cmd != IMC_IDLE) begin
               next_req_tgl = ~req_tgl;
            end else begin
               next_cmd = cmd;
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         ctrl        <= IMC_CTRL_RESET;
         rx_data     <= 8'h00;
         req_tgl     <= 1'b0;
         cmd         <= IMC_IDLE;
         WAITREQUEST <= 1'b1;
         READDATA    <= 32'h00000000;
         done_s1     <= 1'b0;
         done_s2     <= 1'b0;
         done_s3     <= 1'b0;
      end else begin
         ctrl        <= next_ctrl;
         rx_data     <= next_rx_data;
         req_tgl     <= next_req_tgl;
         cmd         <= next_cmd;
         WAITREQUEST <= next_waitreq;
         READDATA    <= next_readdata;
         done_s1     <= lk_done;
         done_s2     <= done_s1;
         done_s3     <= done_s2;
      end
   end

   // ****************************************
   // link side synchronisers
   // ****************************************
   // cmd is steady while a request is pending, though a write can still change ack value; they
   // travel bundled with the synced toggle; the stretch bits go through s1 and s2
   logic       rst_s1;
   logic       rst_s2;
   logic [4:0] s1;
   logic [4:0] s2;
   logic       req_s3;
   logic       sda_s;
   logic       scl_s;
   logic       req_s;
   logic       str_s;
   logic       rel_s;

   always_ff @(posedge LINK_CLK) begin
      rst_s1 <= RST_B;
      rst_s2 <= rst_s1;
      s1     <= {SDA_IN, SCL_IN, req_tgl,
                 ctrl[IMC_B_STRETCH], ctrl[IMC_B_RELEASE]};
      s2     <= s1;
      req_s3 <= s2[2];
   end

   assign {sda_s, scl_s, req_s, str_s, rel_s} = s2;

   // ****************************************
   // bus-condition engine
   // ****************************************
   imc_state_t st;
   imc_state_t next_st;
   logic [1:0] q;
   logic [1:0] next_q;
   logic [7:0] qcnt;
   logic [7:0] next_qcnt;
   logic [2:0] bitn;
   logic [2:0] next_bitn;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic [7:0] next_lk_rx;
   logic       next_lk_done;
   logic       ackv;
   logic       next_ackv;
   logic       own;
   logic       next_own;
   logic       next_sda_oe;
   logic       next_scl_oe;
   logic       tick;
   logic       hold;

   // pin drive {sda_oe, scl_oe} for a quarter of each sequence
   function automatic logic [1:0] drive(imc_state_t s, logic [1:0] p,
                                        logic a);
      logic edge_q;
      edge_q = (p == 2'd0) || (p == 2'd3);
      case (s)
         IMC_START:  drive = {p != 2'd0, p == 2'd3};
         IMC_RSTART: drive = {p[1], p != 2'd1};
         IMC_STOP:   drive = {!p[1], p == 2'd0};
         IMC_RECV:   drive = {1'b0, edge_q};
         IMC_ACK:    drive = {!a, edge_q};
         default:    drive = 2'b00;
      endcase
   endfunction

   always_comb begin
      next_st      = st;
      next_q       = q;
      next_qcnt    = qcnt;
      next_bitn    = bitn;
      next_sh      = sh;
      next_lk_rx   = lk_rx;
      next_lk_done = lk_done;
      next_ackv    = ackv;
      next_own     = own;
      next_sda_oe  = SDA_OE;
      next_scl_oe  = SCL_OE;
      tick         = qcnt == QLAST;
      // a slave holding scl low stretches the high quarter
      hold = (st == IMC_RECV || st == IMC_ACK) && q == 2'd1 && !scl_s;
      case (st)
         IMC_IDLE: begin
            next_q    = 2'd0;
            next_qcnt = 8'h00;
            next_bitn = 3'd0;
            if (!own) begin
               next_sda_oe = 1'b0;
               next_scl_oe = str_s && !rel_s;
            end
            if (req_s != req_s3) begin
               next_st   = cmd;
               next_ackv = ctrl[IMC_B_ACKVAL];
            end
         end
         IMC_START, IMC_RSTART, IMC_STOP, IMC_RECV, IMC_ACK: begin
            if (hold) begin
               next_qcnt = 8'h00;
            end else if (tick) begin
               next_qcnt = 8'h00;
               next_q    = q + 2'd1;
            end else begin
               next_qcnt = qcnt + 8'h01;
            end
            if (st == IMC_RECV && tick && q == 2'd2) begin
               next_sh = {sh[6:0], sda_s};
            end
            if (tick && q == 2'd3) begin
               if (st == IMC_RECV && bitn != 3'(IMC_BITS - 1)) begin
                  next_bitn = bitn + 3'd1;
               end else begin
                  // end of sequence: hand back and clear the go bit
                  next_st      = IMC_IDLE;
                  next_lk_done = ~lk_done;
                  next_lk_rx   = (st == IMC_RECV) ? sh : lk_rx;
                  next_own     = st != IMC_STOP;
               end
            end
         end
         default: begin
            next_st = IMC_IDLE;
         end
      endcase
      // last drive of a sequence is kept while the bus is owned
      if (next_st != IMC_IDLE) begin
         {next_sda_oe, next_scl_oe} = drive(next_st, next_q, next_ackv);
      end
   end

   always_ff @(posedge LINK_CLK) begin
      if (!rst_s2) begin
         st      <= IMC_IDLE;
         q       <= 2'd0;
         qcnt    <= 8'h00;
         bitn    <= 3'd0;
         sh      <= 8'h00;
         lk_rx   <= 8'h00;
         lk_done <= 1'b0;
         ackv    <= 1'b0;
         own     <= 1'b0;
         SDA_OE  <= 1'b0;
         SCL_OE  <= 1'b0;
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
      end else begin
         st      <= next_st;
         q       <= next_q;
         qcnt    <= next_qcnt;
         bitn    <= next_bitn;
         sh      <= next_sh;
         lk_rx   <= next_lk_rx;
         lk_done <= next_lk_done;
         ackv    <= next_ackv;
         own     <= next_own;
         SDA_OE  <= next_sda_oe;
         SCL_OE  <= next_scl_oe;
         // open drain: the level driven is always low
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
      end
   end

endmodule // imc_ctrl

// [src/imc_pkg.sv]
// constants for the i2c master sequence control block
// assumes a 32-bit avalon-mm slave port with byte addressing
package imc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int AW = 4;
   localparam logic [3:0] IMC_OFS_CONTROL = 4'h0;
   localparam logic [3:0] IMC_OFS_RXDATA  = 4'h4;
   localparam logic [15:0] IMC_CTRL_RESET = 16'h0000;
   localparam logic [15:0] IMC_CTRL_MASK  = 16'h187F;

   // ****************************************
   // control fields
   // ****************************************
   localparam int IMC_B_START   = 0;
   localparam int IMC_B_RSTART  = 1;
   localparam int IMC_B_STOP    = 2;
   localparam int IMC_B_RECV    = 3;
   localparam int IMC_B_ACKGO   = 4;
   localparam int IMC_B_ACKVAL  = 5;
   localparam int IMC_B_STRETCH = 6;
   localparam int IMC_B_MGMT    = 11;
   localparam int IMC_B_RELEASE = 12;

   // ****************************************
   // timing
   // ****************************************
   // link clock cycles per quarter of an i2c bit
   localparam int IMC_QTR_CYC = 4;
   localparam int IMC_BITS    = 8;

   typedef enum logic [5:0] {
      IMC_IDLE   = 6'h01,
      IMC_START  = 6'h02,
      IMC_RSTART = 6'h04,
      IMC_STOP   = 6'h08,
      IMC_RECV   = 6'h10,
      IMC_ACK    = 6'h20
   } imc_state_t;

endpackage

// [tb/imc_ctrl_monitor.sv]
// checker for imc_ctrl port timing
// assumes open drain pins pulled up outside
`timescale 1ns/1ps
module imc_ctrl_chk
   import imc_pkg::*;
#(
   parameter int QTR_CYC = IMC_QTR_CYC
) (
   input wire logic        CLK,
   input wire logic        RST_B,
   input wire logic        READ,
   input wire logic        WRITE,
   input wire logic [31:0] READDATA,
   input wire logic        WAITREQUEST,
   input wire logic        LINK_CLK,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   input wire logic        SCL_OUT,
   input wire logic        SCL_OE
);
   AST_WAIT_ONE: assert property (@(posedge CLK) disable iff (!RST_B)
      $rose(READ || WRITE) |-> WAITREQUEST ##1 !WAITREQUEST)
      else $error("answer not one cycle after request");
   AST_WAIT_IDLE: assert property (@(posedge CLK) disable iff (!RST_B)
      !(READ || WRITE) |-> WAITREQUEST)
      else $error("answer without request");
   AST_WAIT_PULSE: assert property (@(posedge CLK) disable iff (!RST_B)
      !WAITREQUEST |=> WAITREQUEST)
      else $error("answer longer than one cycle");
   AST_RD_HOLD: assert property (@(posedge CLK) disable iff (!RST_B)
      !READ |=> $stable(READDATA))
      else $error("read data moved without read");
   AST_RD_UPPER: assert property (@(posedge CLK) disable iff (!RST_B)
      READDATA[31:16] == 16'h0000)
      else $error("upper read data not zero");
   AST_PIN_LOW: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
      !SDA_OUT && !SCL_OUT)
      else $error("open drain level not low");
   AST_START: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
      $rose(SDA_OE) && !SCL_OE |-> ##[1:8] SCL_OE)
      else $error("clock not pulled after start edge");
   AST_STOP: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
      $fell(SDA_OE) && !SCL_OE |=> !SDA_OE [*4])
      else $error("data pulled again after stop");
   AST_QTR: assert property (@(posedge LINK_CLK) disable iff (!RST_B)
      $changed(SCL_OE) && QTR_CYC > 1 |=> $stable(SCL_OE))
      else $error("clock quarter too short");
endmodule // imc_ctrl_chk

bind imc_ctrl imc_ctrl_chk #(.QTR_CYC(QTR_CYC)) imc_ctrl_chk_inst (
   .CLK(CLK), .RST_B(RST_B), .READ(READ), .WRITE(WRITE),
   .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .LINK_CLK(LINK_CLK),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));

// [tb/imc_ctrl_tb.sv]
// bench for imc_ctrl: avalon register tasks, slave model on the pins
// assumes pull-ups on both wires, resolved here
`timescale 1ns/1ps
module imc_ctrl_tb;
   import imc_pkg::*;
   logic          CLK = 1'b0;
   logic          RST_B = 1'b0;
   logic          LINK_CLK = 1'b0;
   logic [AW-1:0] ADDRESS = '0;
   logic          READ = 1'b0;
   logic          WRITE = 1'b0;
   logic [31:0]   WRITEDATA = '0;
   logic [31:0]   READDATA, q;
   logic          WAITREQUEST, SDA_OUT, SDA_OE, SCL_OUT, SCL_OE;
   logic          s_sda, s_scl, slot, load = 1'b0;
   logic [7:0]    tx = 8'h00;
   logic [3:0]    hold = 4'h0;
   int            fail_count = 0, n_tests = 0, cyc = 0;
   wire           sda_w = (SDA_OE ? SDA_OUT : 1'b1) && !s_sda;
   wire           scl_w = (SCL_OE ? SCL_OUT : 1'b1) && !s_scl;

   initial forever #50 CLK = ~CLK;
   initial begin
      #37;
      forever #32 LINK_CLK = ~LINK_CLK;
   end

   imc_ctrl #(.QTR_CYC(2)) imc_ctrl_inst (.CLK(CLK), .RST_B(RST_B),
      .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
      .BYTEENABLE(4'hF), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
      .LINK_CLK(LINK_CLK), .SDA_IN(sda_w), .SDA_OUT(SDA_OUT),
      .SDA_OE(SDA_OE), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE));
   imc_slave imc_slave_inst (.LINK_CLK(LINK_CLK), .SCL(scl_w), .LOAD(load),
      .TX_BYTE(tx), .HOLD(hold), .SDA_PULL(s_sda), .SCL_PULL(s_scl));

   // data level at the rising clock of the last slot
   always @(posedge scl_w) slot = sda_w;

   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge CLK);
      ADDRESS <= a;
      WRITE <= wr;
      READ <= !wr;
      WRITEDATA <= d;
      do @(posedge CLK); while (WAITREQUEST !== 1'b0);
      q = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // launch one sequence, then poll until hardware clears its bit
   task automatic go(input int b, input logic [15:0] extra);
      int i;
      bus(1'b1, IMC_OFS_CONTROL, {16'h0, extra} | (32'h1 << b));
      for (i = 0; i < 100; i++) begin
         bus(1'b0, IMC_OFS_CONTROL, 32'h0);
         if (q[b] === 1'b0) break;
      end
      chk({31'h0, q[b]}, 32'h0);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         end_sim;
      end
   end

   initial begin
      repeat (4) @(posedge CLK);
      RST_B <= 1'b1;
      bus(1'b0, IMC_OFS_CONTROL, 32'h0);
      chk(q, {16'h0, IMC_CTRL_RESET});
      bus(1'b1, 4'h8, 32'hFFFFFFFF);
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, IMC_OFS_CONTROL, 32'hFFFFF8E0);
      bus(1'b0, IMC_OFS_CONTROL, 32'h0);
      chk(q, 32'h1860);
      bus(1'b1, IMC_OFS_CONTROL, 32'h1861);
      bus(1'b0, IMC_OFS_CONTROL, 32'h0);
      chk(q, 32'h1860);
      bus(1'b1, IMC_OFS_CONTROL, 32'h0040);
      repeat (8) @(posedge CLK);
      chk({31'h0, SCL_OE}, 32'h1);
      bus(1'b1, IMC_OFS_CONTROL, 32'h1040);
      repeat (8) @(posedge CLK);
      chk({31'h0, SCL_OE}, 32'h0);
      go(IMC_B_START, 16'h0);
      chk({30'h0, SDA_OE, SCL_OE}, 32'h3);
      for (int i = 0; i < 2; i++) begin
         tx <= (i == 1) ? 8'hA5 : 8'h3C;
         hold <= (i == 1) ? 4'h7 : 4'h0;
         load <= 1'b1;
         go(IMC_B_RECV, 16'h0);
         load <= 1'b0;
         bus(1'b0, IMC_OFS_RXDATA, 32'h0);
         chk(q, (i == 1) ? 32'hA5 : 32'h3C);
         go(IMC_B_ACKGO, (i == 1) ? 16'h0020 : 16'h0);
         chk({31'h0, slot}, 32'(i));
      end
      go(IMC_B_RSTART, 16'h0);
      chk({30'h0, SDA_OE, SCL_OE}, 32'h3);
      go(IMC_B_STOP, 16'h0);
      chk({30'h0, SDA_OE, SCL_OE}, 32'h0);
      end_sim;
   end
endmodule // imc_ctrl_tb

// [tb/imc_slave.sv]
// i2c slave model: one byte msb first, may stretch scl after each fall
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/1ps
module imc_slave (
   input  wire logic       LINK_CLK,
   input  wire logic       SCL,
   input  wire logic       LOAD,
   input  wire logic [7:0] TX_BYTE,
   input  wire logic [3:0] HOLD,
   output logic            SDA_PULL,
   output logic            SCL_PULL
);
   logic       scl_d = 1'b1;
   logic [3:0] cnt = 4'h0;
   logic [3:0] hc = 4'h0;
   always @(posedge LINK_CLK) begin
      scl_d <= SCL;
      if (scl_d && !SCL && LOAD) hc <= HOLD;
      else if (hc != 4'h0) hc <= hc - 4'h1;
      if (!LOAD) cnt <= 4'h0;
      else if (scl_d && !SCL) cnt <= cnt + 4'h1;
   end
   // released data reads high through the pull-up
   assign SDA_PULL = LOAD && cnt < 4'h8 && !TX_BYTE[3'h7 - cnt[2:0]];
   assign SCL_PULL = hc != 4'h0;
endmodule // imc_slave
